// ==== logic/svs_consts.svh ====
`ifndef SVS_CONSTS_SVH
`define SVS_CONSTS_SVH

// ****
// timing
// ****
`define SVS_CLK_HZ 64'd200000000
`define SVS_NOMINAL_HZ 64'd50
`define SVS_SAMPLES_PER_CYCLE 64'd80
`define SVS_DEBOUNCE_MS 64'd20
`define SVS_DEBOUNCE_CYC ((`SVS_DEBOUNCE_MS * `SVS_CLK_HZ + 64'd999) / 64'd1000)
`define SVS_SAMPLE_DIV (`SVS_CLK_HZ / (`SVS_NOMINAL_HZ * `SVS_SAMPLES_PER_CYCLE))
`define SVS_MAX_GAP 4'h3
// error second: loss above 1.25 %, i.e. lost * 80 > expected
`define SVS_ERRSEC_MUL 32'h50

// ****
// register byte offsets
// ****
`define SVS_REG_CTRL 8'h00
`define SVS_REG_THRESH 8'h04
`define SVS_REG_EXPECT 8'h08
`define SVS_REG_CMAP 8'h0C
`define SVS_REG_CT_RATIO 8'h10
`define SVS_REG_VT_RATIO 8'h14
`define SVS_REG_STATUS 8'h18
`define SVS_REG_CLR_TIME 8'h1C
`define SVS_REG_SECONDS 8'h20
`define SVS_REG_MU_BASE 8'h40

// ****
// control fields and reset values
// ****
`define SVS_CTRL_CLEAR 0
`define SVS_CTRL_TRUST_LSB 16
`define SVS_CTRL_RESET 32'h0000_0000
`define SVS_THRESH_RESET 8'h0A
`define SVS_RATIO_RESET 16'h0001

// ****
// secondary limits in mA and mV
// ****
`define SVS_LIM_1A 24'h00FA00
`define SVS_LIM_5A 24'h04E200
`define SVS_LIM_V 24'h030D40

`endif

// ==== logic/svs_pkg.sv ====
package svs_pkg;

   // one merging unit's frame flags for the current sample slot
   typedef struct packed {
      logic valid;
      logic synced;
      logic invalid;
      logic questionable;
      logic [5:0] reason;
      logic test;
      logic freq_60;
   } svs_frame_t;

   // software control word
   typedef struct packed {
      logic [9:0] rsvd_hi;
      logic [5:0] trust;
      logic [5:0] rsvd_lo;
      logic ct_5a;
      logic nominal_60;
      logic sync_required;
      logic test_only;
      logic inhibit_on_test;
      logic accept_questionable;
      logic sat_sync_enable;
      logic phase_diff_enable;
      logic voltage_switch_enable;
      logic clear;
   } svs_ctrl_t;

   // statistics of one merging unit
   typedef struct packed {
      logic [15:0] miss_cyc;
      logic [15:0] miss_sec;
      logic [15:0] per_second_loss_pct;
      logic [31:0] cumulative_lost_frames;
      logic [31:0] error_seconds_count;
      logic [3:0] gap;
      logic seen;
      logic rate_over;
      logic missing;
   } svs_mu_stat_t;

   // alarms and selections as read back
   typedef struct packed {
      logic channel_map_alarm;
      logic sample_quality_alarm;
      logic global_sync_alarm;
      logic setting_conflict_alarm;
      logic prot_inhibit;
      logic diff_inhibit;
      logic [4:0] sel_applied;
   } svs_status_t;

endpackage : svs_pkg

// ==== logic/svs_top.sv ====
// How it works
// - a loss rate per merging unit every power-system cycle
// - below threshold, gaps up to three samples keep protection
// - rate above threshold inhibits protection until it falls
// - per unit lost-frame percentage of the last second
// - cumulative lost frames since clear, and clear time
// - error second when a second's loss exceeds 1.25 percent
// - clear zeroes every unit's loss counts, percentage, error seconds and rate flag; gap count and missing flag are kept
// - voltage switching off after reset, on only when enabled
// - three-phase from set one on select 0, set two on 1
// - new selection applies after 20 ms steady
// - selected voltages shown only while switching enabled
// - check voltage one: 00 source one, 01 two, 10 three, 11 unused
// - check voltage two: 00 source two, 01 three, 10 one, 11 unused
// - clamp secondaries to 64 A, 320 A or 200 V
// - primary = secondary times transformer ratio
// - channel map alarm on illegal current assignment
// - quality alarm on unsynchronised, missing or invalid streams
// - quality alarm on refused questionable, test or untested frames
// - quality alarm on frequency mismatch or secondary over limit
// - sync failure raises alarm, inhibits current differential
// - conflict alarm: phase differential on, satellite sync off
// - questionable data with only trusted reasons keeps protection
//
// The register offsets and the Wishbone register port are this design's own decisions.
`include "svs_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module svs_top #(
   parameter int NUM_MU = 4,
   parameter int unsigned SAMPLE_DIV = 32'(`SVS_SAMPLE_DIV),
   parameter int unsigned DEB_CYCLES = 32'(`SVS_DEBOUNCE_CYC),
   parameter int unsigned SPC = 32'(`SVS_SAMPLES_PER_CYCLE),
   parameter int unsigned CPS = 32'(`SVS_NOMINAL_HZ)
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // sampled-value streams
   input wire svs_pkg::svs_frame_t [NUM_MU-1:0] i_frame,
   input wire logic i_global_sync_ok,
   input wire logic signed [2:0][23:0] i_v3_set1,
   input wire logic signed [2:0][23:0] i_v3_set2,
   input wire logic signed [2:0][23:0] i_vsc_src,
   input wire logic signed [2:0][23:0] i_cur,
   // internal logic selects
   input wire logic i_three_phase_source_sel,
   input wire logic i_check1_sel_first,
   input wire logic i_check1_sel_second,
   input wire logic i_check2_sel_first,
   input wire logic i_check2_sel_second,
   // display and protection outputs
   output logic signed [2:0][23:0] o_v3_disp,
   output logic signed [23:0] o_check_sync_voltage_one,
   output logic signed [23:0] o_check_sync_voltage_two,
   output logic signed [2:0][23:0] o_cur_sec,
   output logic signed [2:0][40:0] o_cur_pri,
   output logic signed [2:0][40:0] o_v3_pri,
   output logic o_prot_inhibit,
   output logic o_diff_inhibit,
   output logic o_channel_map_alarm,
   output logic o_sample_quality_alarm,
   output logic o_global_sync_alarm,
   output logic o_setting_conflict_alarm
);

   // ****
   // state
   // ****
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      svs_pkg::svs_ctrl_t ctrl;
      logic [7:0] thresh;
      logic [NUM_MU-1:0] expect_mask;
      logic [7:0] cmap;
      logic [15:0] ct_ratio;
      logic [15:0] vt_ratio;
      logic [31:0] seconds;
      logic [31:0] clr_time;
      logic [31:0] div_cnt;
      logic [15:0] samp_cnt;
      logic [15:0] cyc_cnt;
      svs_pkg::svs_mu_stat_t [NUM_MU-1:0] mu;
      logic [4:0] sel_pend;
      logic [31:0] deb_cnt;
      svs_pkg::svs_status_t st;
      logic signed [2:0][23:0] v3_disp;
      logic signed [23:0] check_sync_voltage_one;
      logic signed [23:0] check_sync_voltage_two;
      logic signed [2:0][23:0] cur_sec;
      logic signed [2:0][40:0] cur_pri;
      logic signed [2:0][40:0] v3_pri;
   } svs_state_t;

   svs_state_t r;
   svs_state_t next_r;

   // ****
   // helpers
   // ****
   // byte-lane merge for partial wishbone writes
   function automatic logic [31:0] svs_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction : svs_merge

   // symmetric clamp of a secondary sample
   function automatic logic signed [23:0] svs_clamp(input logic signed [23:0] x,
                                                     input logic [23:0] lim);
      logic signed [23:0] l;
      l = $signed(lim);
      if (x > l) begin
         return l;
      end else if (x < -l) begin
         return -l;
      end
      return x;
   endfunction : svs_clamp

   function automatic logic svs_over(input logic signed [23:0] x, input logic [23:0] lim);
      return (x > $signed(lim)) || (x < -$signed(lim));
   endfunction : svs_over

   // secondary times ratio, full width so nothing overflows
   function automatic logic signed [40:0] svs_pri(input logic signed [23:0] x,
                                                   input logic [15:0] ratio);
      return x * $signed({1'b0, ratio});
   endfunction : svs_pri

   // source pick for the check voltages; 2'b11 keeps the previous value
   function automatic logic signed [23:0] svs_pick(input logic [1:0] s,
                                                    input logic [1:0] base,
                                                    input logic signed [2:0][23:0] src,
                                                    input logic signed [23:0] prev);
      logic [1:0] idx;
      idx = 2'((s + base) % 3);
      return (s == 2'h3) ? prev : src[idx];
   endfunction : svs_pick

   // ****
   // next-state logic
   // ****
   always_comb begin
      logic samp_tick;
      logic cyc_tick;
      logic sec_tick;
      logic clr;
      logic wr;
      logic [4:0] sel_raw;
      logic [4:0] app;
      logic [23:0] ilim;
      logic q_bad;
      logic over_lim;
      logic map_bad;
      logic [7:0] adr;
      logic [31:0] lost32;
      int unsigned mi;
      next_r = r;
      adr = i_wb_adr;
      wr = i_wb_cyc && i_wb_stb && i_wb_we && !r.ack;
      clr = 1'b0;
      next_r.ctrl.clear = 1'b0;
      q_bad = 1'b0;
      over_lim = 1'b0;
      lost32 = 32'h0;
      mi = 0;

      // dividers: sample slot, power-system cycle, second
      samp_tick = (r.div_cnt == SAMPLE_DIV - 1);
      cyc_tick = samp_tick && (r.samp_cnt == 16'(SPC - 1));
      sec_tick = cyc_tick && (r.cyc_cnt == 16'(CPS - 1));
      next_r.div_cnt = samp_tick ? 32'h0 : r.div_cnt + 32'h1;
      if (samp_tick) begin
         next_r.samp_cnt = (r.samp_cnt == 16'(SPC - 1)) ? 16'h0 : r.samp_cnt + 16'h1;
      end
      if (cyc_tick) begin
         next_r.cyc_cnt = (r.cyc_cnt == 16'(CPS - 1)) ? 16'h0 : r.cyc_cnt + 16'h1;
      end
      if (sec_tick) begin
         next_r.seconds = r.seconds + 32'h1;
      end

      // wishbone: one wait state, ack dropped the cycle after it was given
      next_r.ack = i_wb_cyc && i_wb_stb && !r.ack;
      if (wr) begin
         unique case (adr)
            `SVS_REG_CTRL: begin
               next_r.ctrl = svs_merge(r.ctrl, i_wb_dat, i_wb_sel);
               clr = i_wb_sel[0] && i_wb_dat[`SVS_CTRL_CLEAR];
            end
            `SVS_REG_THRESH: next_r.thresh = 8'(svs_merge(32'(r.thresh), i_wb_dat, i_wb_sel));
            `SVS_REG_EXPECT: begin
               next_r.expect_mask = NUM_MU'(svs_merge(32'(r.expect_mask), i_wb_dat, i_wb_sel));
            end
            `SVS_REG_CMAP: next_r.cmap = 8'(svs_merge(32'(r.cmap), i_wb_dat, i_wb_sel));
            `SVS_REG_CT_RATIO: begin
               next_r.ct_ratio = 16'(svs_merge(32'(r.ct_ratio), i_wb_dat, i_wb_sel));
            end
            `SVS_REG_VT_RATIO: begin
               next_r.vt_ratio = 16'(svs_merge(32'(r.vt_ratio), i_wb_dat, i_wb_sel));
            end
            default: ;
         endcase
      end
      next_r.ctrl.clear = 1'b0;
      // the clear pulse never stays set in the stored control word
      if (clr) begin
         next_r.clr_time = r.seconds;
      end

      // read mux; unmapped words read zero
      next_r.rdat = 32'h0;
      unique case (adr)
         `SVS_REG_CTRL: next_r.rdat = r.ctrl;
         `SVS_REG_THRESH: next_r.rdat = 32'(r.thresh);
         `SVS_REG_EXPECT: next_r.rdat = 32'(r.expect_mask);
         `SVS_REG_CMAP: next_r.rdat = 32'(r.cmap);
         `SVS_REG_CT_RATIO: next_r.rdat = 32'(r.ct_ratio);
         `SVS_REG_VT_RATIO: next_r.rdat = 32'(r.vt_ratio);
         `SVS_REG_STATUS: next_r.rdat = 32'(r.st);
         `SVS_REG_CLR_TIME: next_r.rdat = r.clr_time;
         `SVS_REG_SECONDS: next_r.rdat = r.seconds;
         default: begin
            if (adr >= `SVS_REG_MU_BASE) begin
               mi = 32'(adr - `SVS_REG_MU_BASE) >> 4;
               if (mi < NUM_MU) begin
                  unique case (adr[3:2])
                     2'h0: next_r.rdat = 32'(r.mu[mi].per_second_loss_pct);
                     2'h1: next_r.rdat = r.mu[mi].cumulative_lost_frames;
                     2'h2: next_r.rdat = r.mu[mi].error_seconds_count;
                     default: next_r.rdat = 32'h0;
                  endcase
               end
            end
         end
      endcase

      // per merging unit loss accounting
      for (int m = 0; m < NUM_MU; m++) begin
         // a frame arriving in the slot's closing cycle still counts
         next_r.mu[m].seen = (r.mu[m].seen && !samp_tick) || i_frame[m].valid;
         if (samp_tick && r.expect_mask[m]) begin
            if (!(r.mu[m].seen || i_frame[m].valid)) begin
               next_r.mu[m].miss_cyc = r.mu[m].miss_cyc + 16'h1;
               next_r.mu[m].miss_sec = r.mu[m].miss_sec + 16'h1;
               next_r.mu[m].cumulative_lost_frames = r.mu[m].cumulative_lost_frames + 32'h1;
               if (r.mu[m].gap != 4'hF) begin
                  next_r.mu[m].gap = r.mu[m].gap + 4'h1;
               end
            end else begin
               next_r.mu[m].gap = 4'h0;
            end
         end
         if (cyc_tick) begin
            // equality is tolerated
            next_r.mu[m].rate_over = (32'(next_r.mu[m].miss_cyc) * 32'd100)
                                     > (32'(r.thresh) * SPC);
            next_r.mu[m].missing = r.expect_mask[m] && (32'(next_r.mu[m].miss_cyc) == SPC);
            next_r.mu[m].miss_cyc = 16'h0;
         end
         if (sec_tick) begin
            lost32 = 32'(next_r.mu[m].miss_sec);
            // in hundredths of a percent
            next_r.mu[m].per_second_loss_pct = 16'((lost32 * 32'd10000) / (SPC * CPS));
            if (lost32 * `SVS_ERRSEC_MUL > SPC * CPS) begin
               next_r.mu[m].error_seconds_count = r.mu[m].error_seconds_count + 32'h1;
            end
            next_r.mu[m].miss_sec = 16'h0;
         end
         if (!r.expect_mask[m]) begin
            next_r.mu[m].gap = 4'h0;
         end
         // clear wins over a same-cycle count
         if (clr) begin
            next_r.mu[m].miss_cyc = 16'h0;
            next_r.mu[m].miss_sec = 16'h0;
            next_r.mu[m].per_second_loss_pct = 16'h0;
            next_r.mu[m].cumulative_lost_frames = 32'h0;
            next_r.mu[m].error_seconds_count = 32'h0;
            next_r.mu[m].rate_over = 1'b0;
         end

         // quality conditions of this stream
         if (r.expect_mask[m] && i_frame[m].valid) begin
            if ((r.ctrl.sync_required && !i_frame[m].synced) || i_frame[m].invalid) begin
               q_bad = 1'b1;
            end
            if (i_frame[m].questionable && !r.ctrl.accept_questionable
                && ((i_frame[m].reason & ~r.ctrl.trust) != 6'h0)) begin
               q_bad = 1'b1;
            end
            if ((i_frame[m].test && r.ctrl.inhibit_on_test)
                || (!i_frame[m].test && r.ctrl.test_only)) begin
               q_bad = 1'b1;
            end
            if (i_frame[m].freq_60 != r.ctrl.nominal_60) begin
               q_bad = 1'b1;
            end
         end
         if (r.mu[m].missing) begin
            q_bad = 1'b1;
         end
      end

      // selection debounce; only a steady level for the full time is applied
      sel_raw = {i_check2_sel_first, i_check2_sel_second, i_check1_sel_first,
                 i_check1_sel_second, i_three_phase_source_sel};
      app = r.st.sel_applied;
      if (sel_raw != r.sel_pend) begin
         next_r.sel_pend = sel_raw;
         next_r.deb_cnt = 32'h0;
      end else if (r.deb_cnt < DEB_CYCLES - 1) begin
         next_r.deb_cnt = r.deb_cnt + 32'h1;
      end else if (r.ctrl.voltage_switch_enable) begin
         app = r.sel_pend;
      end
      if (!r.ctrl.voltage_switch_enable) begin
         app = 5'h00;
      end
      next_r.st.sel_applied = app;

      // voltage routing, gated for the display
      for (int p = 0; p < 3; p++) begin
         next_r.v3_pri[p] = svs_pri(svs_clamp(app[0] ? i_v3_set2[p] : i_v3_set1[p], `SVS_LIM_V),
                                    r.vt_ratio);
         next_r.v3_disp[p] = r.ctrl.voltage_switch_enable
                             ? svs_clamp(app[0] ? i_v3_set2[p] : i_v3_set1[p], `SVS_LIM_V)
                             : 24'sh0;
         if (svs_over(i_v3_set1[p], `SVS_LIM_V) || svs_over(i_v3_set2[p], `SVS_LIM_V)) begin
            over_lim = 1'b1;
         end
      end
      next_r.check_sync_voltage_one = svs_pick({app[2], app[1]}, 2'h0, i_vsc_src, r.check_sync_voltage_one);
      next_r.check_sync_voltage_two = svs_pick({app[4], app[3]}, 2'h1, i_vsc_src, r.check_sync_voltage_two);
      if (!r.ctrl.voltage_switch_enable) begin
         next_r.check_sync_voltage_one = 24'sh0;
         next_r.check_sync_voltage_two = 24'sh0;
      end

      // currents: clamp by input rating, then scale to primary
      ilim = r.ctrl.ct_5a ? `SVS_LIM_5A : `SVS_LIM_1A;
      for (int p = 0; p < 3; p++) begin
         next_r.cur_sec[p] = svs_clamp(i_cur[p], ilim);
         next_r.cur_pri[p] = svs_pri(svs_clamp(i_cur[p], ilim), r.ct_ratio);
         if (svs_over(i_cur[p], ilim)) begin
            over_lim = 1'b1;
         end
      end

      // two current sets must land on different, existing merging units
      map_bad = (r.cmap[1:0] == r.cmap[5:4]) || (32'(r.cmap[1:0]) >= NUM_MU)
                || (32'(r.cmap[5:4]) >= NUM_MU);
      next_r.st.channel_map_alarm = map_bad;
      next_r.st.sample_quality_alarm = q_bad || over_lim;
      next_r.st.global_sync_alarm = !i_global_sync_ok;
      next_r.st.diff_inhibit = !i_global_sync_ok;
      next_r.st.setting_conflict_alarm = r.ctrl.phase_diff_enable
                                         && !r.ctrl.sat_sync_enable;
      // protection inhibit: rate above threshold, gap longer than three, or bad quality
      next_r.st.prot_inhibit = 1'b0;
      for (int m = 0; m < NUM_MU; m++) begin
         if (r.mu[m].rate_over || (next_r.mu[m].gap > `SVS_MAX_GAP)) begin
            next_r.st.prot_inhibit = 1'b1;
         end
      end
      if (q_bad) begin
         next_r.st.prot_inhibit = 1'b1;
      end
   end

   // ****
   // registers
   // ****
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         r <= '0;
         r.ctrl <= `SVS_CTRL_RESET;
         r.thresh <= `SVS_THRESH_RESET;
         r.ct_ratio <= `SVS_RATIO_RESET;
         r.vt_ratio <= `SVS_RATIO_RESET;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register
   assign o_wb_ack = r.ack;
   assign o_wb_dat = r.rdat;
   assign o_v3_disp = r.v3_disp;
   assign o_check_sync_voltage_one = r.check_sync_voltage_one;
   assign o_check_sync_voltage_two = r.check_sync_voltage_two;
   assign o_cur_sec = r.cur_sec;
   assign o_cur_pri = r.cur_pri;
   assign o_v3_pri = r.v3_pri;
   assign o_prot_inhibit = r.st.prot_inhibit;
   assign o_diff_inhibit = r.st.diff_inhibit;
   assign o_channel_map_alarm = r.st.channel_map_alarm;
   assign o_sample_quality_alarm = r.st.sample_quality_alarm;
   assign o_global_sync_alarm = r.st.global_sync_alarm;
   assign o_setting_conflict_alarm = r.st.setting_conflict_alarm;

endmodule : svs_top

`default_nettype wire

// ==== test/svs_mu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****
// merging unit stand-in
// ****
module svs_mu_model #(
   parameter int DIV = 10
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // faults commanded by the bench
   input wire logic [3:0] i_drop,
   input wire logic i_bad,
   // frames toward the device
   output var svs_pkg::svs_frame_t [3:0] o_frame
);
   int cnt;
   // one frame a slot; junk flags when idle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 0;
         o_frame <= '0;
      end else begin
         cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
         for (int m = 0; m < 4; m++) begin
            o_frame[m] <= (cnt == 2 && !i_drop[m]) ? {2'h3, i_bad && m == 0, 9'h000} : 12'h7FF;
         end
      end
   end
endmodule : svs_mu_model
`default_nettype wire

// ==== test/svs_top_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****
// port checker
// ****
module svs_top_checker #(
   parameter int NUM_MU = 4
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // watched ports
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic o_wb_ack,
   input wire svs_pkg::svs_frame_t [NUM_MU-1:0] i_frame,
   input wire logic i_global_sync_ok,
   input wire logic signed [2:0][23:0] i_cur,
   input wire logic signed [2:0][23:0] o_cur_sec,
   input wire logic o_diff_inhibit,
   input wire logic o_channel_map_alarm,
   input wire logic o_sample_quality_alarm,
   input wire logic o_global_sync_alarm
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // a request counts only while no answer stands
   sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
   sequence s_bad; i_frame[0].valid && i_frame[0].invalid; endsequence
   property p_ack; s_req |=> o_wb_ack; endproperty
   property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
   property p_map; $fell(i_rst) |=> o_channel_map_alarm; endproperty
   property p_gsync; 1'b1 |=> o_global_sync_alarm == !$past(i_global_sync_ok); endproperty
   property p_diff; !i_global_sync_ok |=> o_diff_inhibit; endproperty
   property p_bad; s_bad |=> o_sample_quality_alarm; endproperty
   property p_over; $signed(i_cur[0]) > 24'sh04E200 |=> o_sample_quality_alarm; endproperty
   // small currents pass unclamped with one cycle of latency
   property p_pass;
      $signed(i_cur[0]) < 24'sh00FA00 && $signed(i_cur[0]) > -24'sh00FA00
         |=> o_cur_sec[0] == $past(i_cur[0]);
   endproperty
   a_ack: assert property (p_ack) else $error("bus request not answered");
   a_ack_one: assert property (p_ack_one) else $error("bus answer stood too long");
   a_map: assert property (p_map) else $error("map alarm absent after reset");
   a_gsync: assert property (p_gsync) else $error("sync alarm wrong");
   a_diff: assert property (p_diff) else $error("differential not inhibited");
   a_bad: assert property (p_bad) else $error("invalid frame without alarm");
   a_over: assert property (p_over) else $error("over limit without alarm");
   a_pass: assert property (p_pass) else $error("current altered");
endmodule : svs_top_checker
bind svs_top svs_top_checker #(.NUM_MU(NUM_MU)) u_chk (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
   .o_wb_ack, .i_frame, .i_global_sync_ok, .i_cur, .o_cur_sec, .o_diff_inhibit,
   .o_channel_map_alarm, .o_sample_quality_alarm, .o_global_sync_alarm);
`default_nettype wire

// ==== test/svs_top_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module svs_top_tb_top;
   // ****
   // bench signals
   // ****
   logic i_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_global_sync_ok, i_bad;
   logic i_three_phase_source_sel, i_check1_sel_first, i_check1_sel_second;
   logic i_check2_sel_first, i_check2_sel_second, o_prot_inhibit, o_diff_inhibit;
   logic o_channel_map_alarm, o_sample_quality_alarm, o_global_sync_alarm;
   logic o_setting_conflict_alarm;
   logic [3:0] i_wb_sel, i_drop;
   logic [7:0] i_wb_adr;
   logic [31:0] i_wb_dat, o_wb_dat, rdata;
   logic signed [2:0][23:0] i_v3_set1, i_v3_set2, i_vsc_src, i_cur, o_v3_disp, o_cur_sec;
   logic signed [23:0] o_check_sync_voltage_one, o_check_sync_voltage_two;
   logic signed [2:0][40:0] o_cur_pri, o_v3_pri;
   svs_pkg::svs_frame_t [3:0] i_frame;
   logic [2:0] seen;
   logic [23:0] e_one [4] = '{24'h000A00, 24'h000B00, 24'h000C00, 24'h000C00};
   logic [23:0] e_two [4] = '{24'h000B00, 24'h000C00, 24'h000A00, 24'h000A00};
   int miscompares, checked;
   // short counts for simulation
   svs_top #(.SAMPLE_DIV(10), .DEB_CYCLES(20), .SPC(8), .CPS(4)) uut (.i_clk, .i_rst,
      .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
      .i_frame, .i_global_sync_ok, .i_v3_set1, .i_v3_set2, .i_vsc_src, .i_cur,
      .i_three_phase_source_sel, .i_check1_sel_first, .i_check1_sel_second,
      .i_check2_sel_first, .i_check2_sel_second, .o_v3_disp, .o_check_sync_voltage_one,
      .o_check_sync_voltage_two, .o_cur_sec, .o_cur_pri, .o_v3_pri, .o_prot_inhibit,
      .o_diff_inhibit, .o_channel_map_alarm, .o_sample_quality_alarm, .o_global_sync_alarm,
      .o_setting_conflict_alarm);
   svs_mu_model #(.DIV(10)) mu (.i_clk, .i_rst, .i_drop, .i_bad, .o_frame(i_frame));
   task automatic print_verdict;
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask : chk
   // one classic cycle; the request holds until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, w, a, d};
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      rdata = o_wb_dat;
      {i_wb_cyc, i_wb_stb} <= 2'h0;
      if (o_wb_ack !== 1'b1) begin
         miscompares++;
         print_verdict();
      end
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rdata, e);
   endtask : rd
   // levels can be brief, so gather them over a window
   task automatic watch(input int n);
      seen = '0;
      repeat (n) begin
         @(posedge i_clk);
         seen |= {o_prot_inhibit, o_sample_quality_alarm, o_global_sync_alarm};
      end
   endtask : watch
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      {i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} = {4'h8, 40'h0, 4'hF};
      {i_global_sync_ok, i_bad, i_drop, i_three_phase_source_sel} = 7'h40;
      {i_check1_sel_first, i_check1_sel_second, i_check2_sel_first, i_check2_sel_second} = 4'h0;
      i_v3_set1 = {3{24'h000100}};
      i_v3_set2 = {3{24'h000200}};
      i_vsc_src = {24'h000C00, 24'h000B00, 24'h000A00};
      i_cur = {3{24'h001000}};
      miscompares = 0;
      checked = 0;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      rd(8'h04, 32'h0000_000A);
      rd(8'h10, 32'h0000_0001);
      rd(8'h3C, 32'h0000_0000);
      rd(8'h18, 32'h0000_0400);
      wb(1'b1, 8'h0C, 32'h0000_0010);
      wb(1'b1, 8'h08, 32'h0000_000F);
      wb(1'b1, 8'h04, 32'h0000_0019);
      wb(1'b1, 8'h10, 32'h0000_0003);
      wb(1'b1, 8'h00, 32'h0000_0004);
      rd(8'h18, 32'h0000_0080);
      i_three_phase_source_sel <= 1'b1;
      repeat (30) @(posedge i_clk);
      chk(o_v3_disp[0], 24'h000000);
      wb(1'b1, 8'h00, 32'h0000_000E);
      repeat (30) @(posedge i_clk);
      chk(o_setting_conflict_alarm, 1'b0);
      chk(o_v3_disp[0], 24'h000200);
      i_three_phase_source_sel <= 1'b0;
      repeat (10) @(posedge i_clk);
      i_three_phase_source_sel <= 1'b1;
      repeat (30) @(posedge i_clk);
      chk(o_v3_disp[0], 24'h000200);
      i_three_phase_source_sel <= 1'b0;
      repeat (30) @(posedge i_clk);
      chk(o_v3_disp[0], 24'h000100);
      for (int k = 0; k < 4; k++) begin
         {i_check1_sel_first, i_check1_sel_second} <= 2'(k);
         {i_check2_sel_first, i_check2_sel_second} <= 2'(k);
         repeat (30) @(posedge i_clk);
         chk(o_check_sync_voltage_one, e_one[k]);
         chk(o_check_sync_voltage_two, e_two[k]);
      end
      i_cur[0] <= 24'h061A80;
      watch(4);
      chk(o_cur_sec[0], 24'h00FA00);
      chk(o_cur_pri[0], 41'h0002EE00);
      chk(o_v3_pri[0], 41'h100);
      chk(seen[1], 1'b1);
      i_cur[0] <= 24'h001000;
      i_bad <= 1'b1;
      watch(30);
      chk(seen[1], 1'b1);
      i_bad <= 1'b0;
      i_global_sync_ok <= 1'b0;
      watch(3);
      chk(seen[0] & o_diff_inhibit, 1'b1);
      wb(1'b1, 8'h00, 32'h0000_004E);
      watch(30);
      chk(seen[1], 1'b1);
      wb(1'b1, 8'h00, 32'h0000_000E);
      i_global_sync_ok <= 1'b1;
      i_drop <= 4'h2;
      repeat (20) @(posedge i_clk);
      i_drop <= 4'h0;
      watch(200);
      chk(seen[2], 1'b0);
      i_drop <= 4'h2;
      watch(70);
      i_drop <= 4'h0;
      chk(seen[2], 1'b1);
      repeat (550) @(posedge i_clk);
      chk(o_prot_inhibit, 1'b0);
      rd(8'h54, 32'h0000_0009);
      rd(8'h40, 32'h0000_0000);
      wb(1'b0, 8'h58, 32'h0);
      chk(rdata != 32'h0, 1'b1);
      wb(1'b1, 8'h00, 32'h0000_000F);
      rd(8'h54, 32'h0000_0000);
      rd(8'h58, 32'h0000_0000);
      print_verdict();
   end
endmodule : svs_top_tb_top
`default_nettype wire
